// ==== pkg/eif_consts.vh ====
// Constants for the external interrupt front end
`ifndef EIF_CONSTS_VH
`define EIF_CONSTS_VH

// ----------------------------------------------------------------
// Clock rates
// ----------------------------------------------------------------
`define EIF_FC_HZ        64'd50000000
`define EIF_CLK_HZ       64'd50000000

// ----------------------------------------------------------------
// Noise reject times, in periods of fc
// ----------------------------------------------------------------
`define EIF_REJ_AF_FC    64'd2
`define EIF_REJ_B_SH_FC  64'd15
`define EIF_REJ_B_LG_FC  64'd63
`define EIF_REJ_CDE_FC   64'd7

// ----------------------------------------------------------------
// Control register location and fields
// ----------------------------------------------------------------
`define EIF_CFG_ADDR     8'h37
`define EIF_CFG_RST      8'h00
`define EIF_BIT_FSEL     7
`define EIF_BIT_PFUNC    6
`define EIF_E_HI         5
`define EIF_E_LO         4
`define EIF_D_HI         3
`define EIF_D_LO         2
`define EIF_BIT_C        1
`define EIF_BIT_B        0

// ----------------------------------------------------------------
// Edge modes
// ----------------------------------------------------------------
`define EIF_MODE_RISE    2'h0
`define EIF_MODE_FALL    2'h1
`define EIF_MODE_BOTH    2'h2
`define EIF_MODE_HIGH    2'h3

// ----------------------------------------------------------------
// Opcodes and memory areas
// ----------------------------------------------------------------
`define EIF_SOFT_TRAP_OP 8'hFF
`define EIF_SFR_LO       16'h0000
`define EIF_SFR_HI       16'h003F
`define EIF_DBR_LO       16'h1F80
`define EIF_DBR_HI       16'h1FFF
`define EIF_SETTLE_W     2
`define EIF_CNT_W        8

`endif

// ==== core/eif_noise_filter.v ====
// Pin synchroniser and digital noise reject filter
`timescale 1ns/1ps
module eif_noise_filter #(
  parameter CNT_W = 8
) (
  clk_sys,
  nrst,
  pin_raw,
  reject_cnt,
  level_q,
  settled_q
);
  input  wire             clk_sys;
  input  wire             nrst;
  input  wire             pin_raw;
  input  wire [CNT_W-1:0] reject_cnt;
  output reg              level_q;
  output reg              settled_q;

  reg             meta_q;
  reg             sync_q;
  reg             seen_q;
  reg [CNT_W-1:0] cnt_q;

  // ----------------------------------------------------------------
  // Two-stage synchroniser, first stage read only by the second
  // ----------------------------------------------------------------
  // No reset: the stages follow an idle pin through reset, so a pin
  // that rests high gives no false edge when reset lifts
  always @(posedge clk_sys) begin
    meta_q <= pin_raw;
    sync_q <= meta_q;
  end

  // Level changes only after it stood stable for reject_cnt cycles
  always @(posedge clk_sys) begin
    if (!nrst) begin
      level_q   <= 1'b0;
      cnt_q     <= {CNT_W{1'b0}};
      seen_q    <= 1'b0;
      settled_q <= 1'b0;
    end else if (!settled_q) begin
      // First sample after reset loads the level with no edge
      seen_q    <= 1'b1;
      settled_q <= seen_q;
      level_q   <= sync_q;
    end else if (sync_q == level_q) begin
      cnt_q <= {CNT_W{1'b0}};
    end else if (cnt_q + 1'b1 >= reject_cnt) begin
      level_q <= sync_q;
      cnt_q   <= {CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // eif_noise_filter

// ==== core/eif_edge_detect.v ====
// Edge and level event detector on a filtered line
`timescale 1ns/1ps
`include "eif_consts.vh"
module eif_edge_detect (
  clk_sys,
  nrst,
  level,
  settled,
  mode,
  event_q
);
  input  wire       clk_sys;
  input  wire       nrst;
  input  wire       level;
  input  wire       settled;
  input  wire [1:0] mode;
  output reg        event_q;

  reg  prev_q;
  reg  armed_q;
  wire rise;
  wire fall;

  assign rise = settled & level & ~prev_q;
  assign fall = settled & ~level & prev_q;

  // ----------------------------------------------------------------
  // Previous level, arm flag for level mode, event decode
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!nrst) begin
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      // Track the level through the settle window, so the first
      // settled cycle compares like with like and sees no edge
      prev_q <= level;
      if (rise)
        armed_q <= 1'b1;
      case (mode)
        `EIF_MODE_RISE: event_q <= rise;
        `EIF_MODE_FALL: event_q <= fall;
        `EIF_MODE_BOTH: event_q <= rise | fall;
        `EIF_MODE_HIGH: event_q <= settled & level & (armed_q | rise);
        default:        event_q <= 1'b0;
      endcase
    end
  end
endmodule // eif_edge_detect

// ==== core/eif_front_end.v ====
// External interrupt request front end with soft trap and fetch checks
`timescale 1ns/1ps
`include "eif_consts.vh"

// Overview of operation
// - Soft trap opcode raises top priority soft trap request immediately.
// - During non-maskable service the soft trap opcode is a plain no-op.
// - Single chip fetch from absent memory returns FF, raising a soft trap.
// - Fetch from RAM, buffer area or register area raises address trap reset.
// - Six external lines, each with its own noise reject filter.
// - Line a pin comes up from reset as a port bit.
// - Lines a and f trigger on falling edge; reject under 2, accept 6 fc.
// - With pin function 0 a falling edge on line a sets no latch.
// - Pin function bit: 0 port, 1 interrupt; port bit set input first.
// - Line b accepts 48 fc pulses short, 192 fc pulses long.
// - Line b filter select 0 rejects under 63 fc, 1 under 15 fc.
// - Lines c to e reject under 7 fc and accept 24 fc.
// - Latch set within 49 or 193 fc for b, 25 fc for c to e.
// - One-bit edge select of lines b, c: 0 rising, 1 falling.
// - Two-bit edge select of d, e: rising, falling, both, high level.
// - Line e high level needs a rising edge after reset release.
// - New line b reject time acts within 64 fc of the write.
// - Driving a shared pin may fake a request; software masks it.
// - Config bit 7 filter select, bit 6 pin function, reset zero.
// - A set latch holds until accepted, reset or cleared by instruction.
module eif_front_end #(
  parameter [15:0] RAM_LO  = 16'h0040,
  parameter [15:0] RAM_HI  = 16'h083F,
  parameter [15:0] ROM_LO  = 16'hC000,
  parameter [15:0] ROM_HI  = 16'hFFFF,
  parameter        N_LINES = 6
) (
  clk_sys,
  nrst,
  ext_irq_pins,
  sfr_addr,
  sfr_wr,
  sfr_rd,
  sfr_wdata,
  sfr_rdata,
  irq_accept,
  irq_clear,
  irq_request,
  inst_exec,
  inst_opcode,
  nmi_in_service,
  soft_accept,
  soft_trap_request,
  no_operation,
  single_chip_mode,
  fetch_req,
  fetch_addr,
  mem_rdata,
  fetch_data,
  address_error,
  addr_trap_reset,
  shared_port_bit_a_is_port
);
  input  wire               clk_sys;
  input  wire               nrst;
  input  wire [N_LINES-1:0] ext_irq_pins;     // Bit 0 line a .. bit 5 line f
  input  wire [7:0]         sfr_addr;
  input  wire               sfr_wr;
  input  wire               sfr_rd;
  input  wire [7:0]         sfr_wdata;
  output reg  [7:0]         sfr_rdata;
  input  wire [N_LINES-1:0] irq_accept;       // Acceptance clears a latch
  input  wire [N_LINES-1:0] irq_clear;        // Instruction clears a latch
  output wire [N_LINES-1:0] irq_request;
  input  wire               inst_exec;        // Opcode executed this cycle
  input  wire [7:0]         inst_opcode;
  input  wire               nmi_in_service;
  input  wire               soft_accept;
  output reg                soft_trap_request;
  output reg                no_operation;
  input  wire               single_chip_mode;
  input  wire               fetch_req;
  input  wire [15:0]        fetch_addr;
  input  wire [7:0]         mem_rdata;
  output reg  [7:0]         fetch_data;
  output reg                address_error;
  output reg                addr_trap_reset;
  output wire               shared_port_bit_a_is_port;

  // ----------------------------------------------------------------
  // Reject counts in clock cycles, rounded up from fc periods
  // ----------------------------------------------------------------
  localparam [63:0] REJ_AF_64 =
    (`EIF_REJ_AF_FC * `EIF_CLK_HZ + `EIF_FC_HZ - 64'd1) / `EIF_FC_HZ;
  localparam [63:0] REJ_BS_64 =
    (`EIF_REJ_B_SH_FC * `EIF_CLK_HZ + `EIF_FC_HZ - 64'd1) / `EIF_FC_HZ;
  localparam [63:0] REJ_BL_64 =
    (`EIF_REJ_B_LG_FC * `EIF_CLK_HZ + `EIF_FC_HZ - 64'd1) / `EIF_FC_HZ;
  localparam [63:0] REJ_CDE_64 =
    (`EIF_REJ_CDE_FC * `EIF_CLK_HZ + `EIF_FC_HZ - 64'd1) / `EIF_FC_HZ;
  localparam [`EIF_CNT_W-1:0] REJ_AF  = REJ_AF_64[`EIF_CNT_W-1:0];
  localparam [`EIF_CNT_W-1:0] REJ_BS  = REJ_BS_64[`EIF_CNT_W-1:0];
  localparam [`EIF_CNT_W-1:0] REJ_BL  = REJ_BL_64[`EIF_CNT_W-1:0];
  localparam [`EIF_CNT_W-1:0] REJ_CDE = REJ_CDE_64[`EIF_CNT_W-1:0];

  // Line indices
  localparam LN_A = 0;
  localparam LN_B = 1;
  localparam LN_C = 2;
  localparam LN_D = 3;
  localparam LN_E = 4;
  localparam LN_F = 5;

  reg  [7:0]                  cfg_q;
  reg  [7:0]                  cfg_d;
  reg  [N_LINES-1:0]          latch_q;
  reg  [N_LINES-1:0]          latch_d;
  reg  [`EIF_CNT_W-1:0]       rej_cnt [0:N_LINES-1];
  reg  [1:0]                  mode    [0:N_LINES-1];
  wire [N_LINES-1:0]          filt_level;
  wire [N_LINES-1:0]          filt_settled;
  wire [N_LINES-1:0]          line_event;
  wire [N_LINES-1:0]          line_gate;
  wire                        cfg_sel;
  wire                        fsel;
  wire                        pfunc;
  wire                        is_sfr;
  wire                        is_dbr;
  wire                        is_ram;
  wire                        in_rom;
  wire                        absent;
  wire                        trap_exec;
  integer                     k;

  // ----------------------------------------------------------------
  // Register access at the documented location
  // ----------------------------------------------------------------
  assign cfg_sel = (sfr_addr == `EIF_CFG_ADDR);
  assign fsel    = cfg_q[`EIF_BIT_FSEL];
  assign pfunc   = cfg_q[`EIF_BIT_PFUNC];

  // Next value of the control register
  always @* begin
    cfg_d = cfg_q;
    if (sfr_wr && cfg_sel)
      cfg_d = sfr_wdata;
  end

  // Control register, zero after reset so line a is a port bit
  always @(posedge clk_sys) begin
    if (!nrst)
      cfg_q <= `EIF_CFG_RST;
    else
      cfg_q <= cfg_d;
  end

  // Read data, registered; other addresses read as zero
  always @(posedge clk_sys) begin
    if (!nrst)
      sfr_rdata <= 8'h00;
    else if (sfr_rd && cfg_sel)
      sfr_rdata <= cfg_q;
    else
      sfr_rdata <= 8'h00;
  end

  // Pin function bit picks port use (0) or interrupt use (1)
  assign shared_port_bit_a_is_port = ~pfunc;

  // ----------------------------------------------------------------
  // Per-line reject time and edge mode
  // ----------------------------------------------------------------
  always @* begin
    for (k = 0; k < N_LINES; k = k + 1) begin
      rej_cnt[k] = REJ_CDE;
      mode[k]    = `EIF_MODE_FALL;
    end
    rej_cnt[LN_A] = REJ_AF;
    rej_cnt[LN_F] = REJ_AF;
    // Selection takes effect on the next count, well inside 64 fc
    rej_cnt[LN_B] = fsel ? REJ_BS : REJ_BL;
    mode[LN_A]    = `EIF_MODE_FALL;
    mode[LN_F]    = `EIF_MODE_FALL;
    mode[LN_B]    = {1'b0, cfg_q[`EIF_BIT_B]};
    mode[LN_C]    = {1'b0, cfg_q[`EIF_BIT_C]};
    mode[LN_D]    = cfg_q[`EIF_D_HI:`EIF_D_LO];
    mode[LN_E]    = cfg_q[`EIF_E_HI:`EIF_E_LO];
  end

  // ----------------------------------------------------------------
  // One filter and one edge detector per line
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_LINES; g = g + 1) begin : g_line
      // Pin passes two flops, then the filter, then the detector
      eif_noise_filter #(
        .CNT_W      (`EIF_CNT_W)
      ) u_filt (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .pin_raw    (ext_irq_pins[g]),
        .reject_cnt (rej_cnt[g]),
        .level_q    (filt_level[g]),
        .settled_q  (filt_settled[g])
      );

      // High level mode waits for a rising edge after reset
      eif_edge_detect u_edge (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .level      (filt_level[g]),
        .settled    (filt_settled[g]),
        .mode       (mode[g]),
        .event_q    (line_event[g])
      );

      // Only line a is gated by its pin function
      if (g == LN_A) begin : g_gate_a
        assign line_gate[g] = line_event[g] & pfunc;
      end else begin : g_gate_n
        // Shared pins driven as outputs still reach the latch; masked by enables
        assign line_gate[g] = line_event[g];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Request latches: set wins over accept or clear
  // ----------------------------------------------------------------
  always @* begin
    latch_d = (latch_q & ~(irq_accept | irq_clear)) | line_gate;
  end

  // Latch set one cycle after the event, inside the signal time
  always @(posedge clk_sys) begin
    if (!nrst)
      latch_q <= {N_LINES{1'b0}};
    else
      latch_q <= latch_d;
  end

  assign irq_request = latch_q;

  // ----------------------------------------------------------------
  // Soft trap opcode: request unless non-maskable service runs
  // ----------------------------------------------------------------
  assign trap_exec = inst_exec && (inst_opcode == `EIF_SOFT_TRAP_OP);

  // Request held until the CPU accepts it; new trap wins the clear
  always @(posedge clk_sys) begin
    if (!nrst) begin
      soft_trap_request <= 1'b0;
      no_operation      <= 1'b0;
    end else begin
      if (trap_exec && !nmi_in_service)
        soft_trap_request <= 1'b1;
      else if (soft_accept)
        soft_trap_request <= 1'b0;
      no_operation <= trap_exec && nmi_in_service;
    end
  end

  // ----------------------------------------------------------------
  // Fetch address checks
  // ----------------------------------------------------------------
  assign is_sfr = (fetch_addr >= `EIF_SFR_LO) && (fetch_addr <= `EIF_SFR_HI);
  assign is_dbr = (fetch_addr >= `EIF_DBR_LO) && (fetch_addr <= `EIF_DBR_HI);
  assign is_ram = (fetch_addr >= RAM_LO) && (fetch_addr <= RAM_HI);
  assign in_rom = (fetch_addr >= ROM_LO) && (fetch_addr <= ROM_HI);
  assign absent = single_chip_mode && !in_rom && !is_sfr && !is_dbr && !is_ram;

  // Absent memory reads back as the soft trap opcode
  always @(posedge clk_sys) begin
    if (!nrst) begin
      fetch_data      <= 8'h00;
      address_error   <= 1'b0;
      addr_trap_reset <= 1'b0;
    end else begin
      if (fetch_req)
        fetch_data <= absent ? `EIF_SOFT_TRAP_OP : mem_rdata;
      address_error   <= fetch_req && absent;
      addr_trap_reset <= fetch_req && (is_sfr || is_dbr || is_ram);
    end
  end
endmodule // eif_front_end

// ==== sim/eif_front_end_asserts.sv ====
// Assertion checker for the external interrupt front end
`timescale 1ns/1ps
module eif_front_end_asserts (
  input wire        clk_sys,
  input wire        nrst,
  input wire [5:0]  ext_irq_pins,
  input wire [7:0]  sfr_addr,
  input wire        sfr_wr,
  input wire [7:0]  sfr_wdata,
  input wire [5:0]  irq_accept,
  input wire [5:0]  irq_clear,
  input wire [5:0]  irq_request,
  input wire        inst_exec,
  input wire [7:0]  inst_opcode,
  input wire        nmi_in_service,
  input wire        soft_accept,
  input wire        soft_trap_request,
  input wire        no_operation,
  input wire        single_chip_mode,
  input wire        fetch_req,
  input wire [15:0] fetch_addr,
  input wire [7:0]  fetch_data,
  input wire        address_error,
  input wire        addr_trap_reset,
  input wire        shared_port_bit_a_is_port
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // Fetch areas: registers, RAM and buffer area trap, the two holes below program memory are absent
  wire trap_area = fetch_addr <= 16'h083F || (fetch_addr >= 16'h1F80 && fetch_addr <= 16'h1FFF);
  wire absent    = !trap_area && fetch_addr < 16'hC000;
  wire soft_op   = inst_exec && inst_opcode == 8'hFF;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_port_held; shared_port_bit_a_is_port [*6]; endsequence
  sequence s_f_quiet; ext_irq_pins[5] [*8] ##1 !ext_irq_pins[5] [*8]; endsequence
  property p_soft_set; soft_op && !nmi_in_service && !soft_accept |=> soft_trap_request; endproperty
  property p_soft_nop;
    soft_op && nmi_in_service && !soft_trap_request |=> no_operation && !soft_trap_request;
  endproperty
  property p_absent;
    fetch_req && single_chip_mode && absent |=> fetch_data == 8'hFF && address_error;
  endproperty
  property p_trap; fetch_req && trap_area |=> addr_trap_reset && !address_error; endproperty
  property p_port_rst; $rose(nrst) |-> shared_port_bit_a_is_port && irq_request == 6'h00; endproperty
  property p_pin_func;
    sfr_wr && sfr_addr == 8'h37 |=> shared_port_bit_a_is_port == !$past(sfr_wdata[6]);
  endproperty
  property p_latch_hold;
    1'b1 |=> ($past(irq_request) & ~$past(irq_accept) & ~$past(irq_clear) & ~irq_request) == 6'h00;
  endproperty
  property p_line_a_off; s_port_held |-> !$rose(irq_request[0]); endproperty
  property p_f_fall; s_f_quiet |-> ##[0:3] irq_request[5]; endproperty
  a_soft_set: assert property (p_soft_set) else $error("soft trap not raised");
  a_soft_nop: assert property (p_soft_nop) else $error("soft trap not a no-op");
  a_absent: assert property (p_absent) else $error("absent fetch not flagged");
  a_trap: assert property (p_trap) else $error("trap reset missing");
  a_port_rst: assert property (p_port_rst) else $error("pin not port after reset");
  a_pin_func: assert property (p_pin_func) else $error("pin function wrong");
  a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");
  a_line_a_off: assert property (p_line_a_off) else $error("port pin latched");
  a_f_fall: assert property (p_f_fall) else $error("line f edge missed");
endmodule // eif_front_end_asserts

// ==== sim/eif_pin_source.sv ====
// Model of the pin sources and the CPU side that accepts requests
`timescale 1ns/1ps
module eif_pin_source (
  input  wire       clk_sys,
  input  wire       nrst,
  input  wire [5:0] pin_level,
  input  wire [5:0] irq_enable,
  input  wire       slow,
  input  wire [5:0] irq_request,
  output wire [5:0] ext_irq_pins,
  output reg  [5:0] irq_accept
);
  reg  [3:0] wait_q;
  wire [5:0] pend = irq_request & irq_enable;
  // Accept the lowest pending line after a short or long service time
  always @(posedge clk_sys) begin
    irq_accept <= 6'h00;
    if (!nrst) begin
      wait_q <= 4'h0;
    end else if (pend != 6'h00 && irq_accept == 6'h00) begin
      if (wait_q == (slow ? 4'hF : 4'h1)) begin
        irq_accept <= pend & (~pend + 6'h01);
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
  // Sources drive clean levels
  assign ext_irq_pins = pin_level;
endmodule // eif_pin_source

// ==== sim/tb_eif_front_end.sv ====
// Self-checking bench for the external interrupt front end
`timescale 1ns/1ps
module tb_eif_front_end;
  logic        clk_sys = '0, nrst = '0, sfr_wr = '0, sfr_rd = '0, inst_exec = '0, slow = '0;
  logic        nmi_in_service = '0, soft_accept = '0, single_chip_mode = '0, fetch_req = '0;
  logic [7:0]  sfr_addr = '0, sfr_wdata = '0, inst_opcode = '0, mem_rdata = '0;
  logic [5:0]  pin_level = 6'h3F, irq_enable = '0, irq_clear = '0;
  logic [15:0] fetch_addr = '0;
  logic [31:0] rnd;
  wire  [7:0]  sfr_rdata, fetch_data;
  wire  [5:0]  ext_irq_pins, irq_accept, irq_request;
  wire         soft_trap_request, no_operation, address_error, addr_trap_reset;
  wire         shared_port_bit_a_is_port;
  int          failures = 0, tests_run = 0, cyc = 0;
  int rej_t[2][6] = '{'{2, 63, 7, 7, 7, 2}, '{2, 15, 7, 7, 7, 2}};
  int acc_t[2][6] = '{'{6, 192, 24, 24, 24, 6}, '{6, 48, 24, 24, 24, 6}};
  int lim_t[2][6] = '{'{8, 193, 25, 25, 25, 8}, '{8, 49, 25, 25, 25, 8}};
  logic [15:0] adr_t[12] = '{16'h0000, 16'h003F, 16'h0040, 16'h083F, 16'h0840, 16'h1F7F,
                             16'h1F80, 16'h1FFF, 16'h2000, 16'hBFFF, 16'hC000, 16'hFFFF};
  eif_front_end dut_u (.clk_sys, .nrst, .ext_irq_pins, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .irq_accept, .irq_clear, .irq_request, .inst_exec, .inst_opcode, .nmi_in_service,
    .soft_accept, .soft_trap_request, .no_operation, .single_chip_mode, .fetch_req, .fetch_addr,
    .mem_rdata, .fetch_data, .address_error, .addr_trap_reset, .shared_port_bit_a_is_port);
  eif_pin_source src_u (.clk_sys, .nrst, .pin_level, .irq_enable, .slow, .irq_request,
    .ext_irq_pins, .irq_accept);
  // ------------------------------------------------------------
  // Clock, timeout and helpers
  // ------------------------------------------------------------
  always #10 clk_sys = ~clk_sys;
  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask
  task automatic clr();
    irq_clear = 6'h3F;
    wait_n(1);
    irq_clear = 6'h00;
  endtask
  task automatic pulse(input int i, input int len, input int tot);
    pin_level[i] = 1'b0;
    wait_n(len);
    pin_level[i] = 1'b1;
    if (tot > len) wait_n(tot - len);
  endtask
  task automatic run_op(input logic [7:0] op, input logic nmi);
    @(negedge clk_sys);
    inst_exec = 1'b1;
    inst_opcode = op;
    nmi_in_service = nmi;
    @(negedge clk_sys);
    inst_exec = 1'b0;
    chk({6'h00, soft_trap_request, no_operation}, {6'h00, op == 8'hFF && !nmi, op == 8'hFF && nmi});
    soft_accept = 1'b1;
    @(negedge clk_sys);
    soft_accept = 1'b0;
  endtask
  task automatic fetch(input logic [15:0] a, input logic scm);
    logic trap, gone;
    trap = a <= 16'h083F || (a >= 16'h1F80 && a <= 16'h1FFF);
    gone = scm && !trap && a < 16'hC000;
    @(negedge clk_sys);
    fetch_req = 1'b1;
    fetch_addr = a;
    single_chip_mode = scm;
    mem_rdata = rnd[31:24];
    @(negedge clk_sys);
    fetch_req = 1'b0;
    chk(fetch_data, gone ? 8'hFF : mem_rdata);
    chk({6'h00, address_error, addr_trap_reset}, {6'h00, gone, trap});
  endtask
  // Lines b, c then d, e expected after a rise or a fall in mode m
  function automatic logic [7:0] edge_exp(input int m, input bit rise);
    logic e;
    e = rise ? (m != 1) : (m != 0);
    return {4'h0, e, e, rise ^ m[0], rise ^ m[0]};
  endfunction
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h01BD));
    wait_n(3);
    nrst = 1'b1;
    reg_rd(8'h37, 8'h00);
    reg_rd(8'h36, 8'h00);
    chk({7'h00, shared_port_bit_a_is_port}, 8'h01);
    reg_wr(8'h37, 8'h70);
    wait_n(30);
    chk({7'h00, irq_request[4]}, 8'h00);
    pulse(4, 30, 60);
    chk({7'h00, irq_request[4]}, 8'h01);
    repeat (4) begin
      rnd = $urandom;
      reg_wr(8'h37, rnd[7:0]);
      reg_rd(8'h37, rnd[7:0]);
      chk({7'h00, shared_port_bit_a_is_port}, {7'h00, !rnd[6]});
    end
    for (int m = 0; m < 4; m++) begin
      reg_wr(8'h37, {2'h3, m[1:0], m[1:0], m[0], m[0]});
      pin_level[4:1] = 4'h0;
      wait_n(40);
      clr();
      pin_level[4:1] = 4'hF;
      wait_n(30);
      chk({4'h0, irq_request[4:1]}, edge_exp(m, 1));
      clr();
      pin_level[4:1] = 4'h0;
      wait_n(30);
      chk({4'h0, irq_request[4:1]}, edge_exp(m, 0));
    end
    pin_level = 6'h3F;
    for (int f = 0; f < 2; f++) begin
      reg_wr(8'h37, {f[0], 7'h57});
      wait_n(80);
      clr();
      for (int i = 0; i < 6; i++) begin
        pulse(i, $urandom_range(rej_t[f][i] - 1, 1), rej_t[f][i] + 10);
        chk({7'h00, irq_request[i]}, 8'h00);
        pulse(i, $urandom_range(lim_t[f][i], acc_t[f][i]), lim_t[f][i]);
        chk({7'h00, irq_request[i]}, 8'h01);
        clr();
      end
    end
    reg_wr(8'h37, 8'h97);
    clr();
    pulse(0, 10, 20);
    chk({7'h00, irq_request[0]}, 8'h00);
    irq_enable = 6'h20;
    slow = 1'b1;
    pulse(5, 10, 12);
    chk({7'h00, irq_request[5]}, 8'h01);
    wait_n(30);
    chk({7'h00, irq_request[5]}, 8'h00);
    run_op(8'hFF, 1'b0);
    run_op(8'hFF, 1'b1);
    rnd = $urandom;
    run_op({1'b0, rnd[6:0]}, rnd[8]);
    for (int i = 0; i < 18; i++) begin
      rnd = $urandom;
      fetch(i < 12 ? adr_t[i % 12] : rnd[15:0], i < 12 || rnd[16]);
    end
    wrap_up();
  end
endmodule // tb_eif_front_end

bind eif_front_end eif_front_end_asserts chk_u (.clk_sys, .nrst, .ext_irq_pins, .sfr_addr,
  .sfr_wr, .sfr_wdata, .irq_accept, .irq_clear, .irq_request, .inst_exec, .inst_opcode,
  .nmi_in_service, .soft_accept, .soft_trap_request, .no_operation, .single_chip_mode,
  .fetch_req, .fetch_addr, .fetch_data, .address_error, .addr_trap_reset,
  .shared_port_bit_a_is_port);
